// ===== design/pdl_bank.sv
/*
 * Peripheral disable and configuration lock register bank.
 * Holds six disable registers and config_control, runs the unlock
 * sequence, and forwards module accesses and pin-select writes through pdl_gate.
 * Assumes the module and pin-select fabric present read data for the
 * current bus address in the same cycle, on sys_clk.
 */
// Strobed register access and the address map were chosen for this implementation.
//
// Contract
// - Disabled module gets no clock at all
// - Bit one disables, zero enables, reset zero
// - Disabled module ignores writes, reads invalid
// - Converter, current unit, reference, comparator bit positions
// - Capture, compare and timer bit positions
// - Serial, bus, calendar, clock, parallel bit positions
// - Pin-select lock blocks pin-select writes
// - Disable lock blocks disable register writes
// - Lock flags change only after unlock
// - Bit three enables debug port, reset zero
// - Bit zero selects data-out use, reset one
// - Unimplemented config bits read zero
`timescale 1ns/100ps
`default_nettype none

module pdl_bank
    import pdl_pkg::*;
(
    input  wire logic               sys_clk,      // System clock, 50 MHz
    input  wire logic               sys_rst,      // Async reset, high
    input  wire logic [ADDR_W-1:0]  addr,         // Byte address
    input  wire logic [31:0]        wr_data,      // Write data
    input  wire logic               wr_en,        // Write strobe
    input  wire logic               rd_en,        // Read strobe
    output logic      [31:0]        rd_data,      // Read data, next cycle
    input  wire logic [31:0]        periph_rdata, // Fabric read data
    output logic      [NUM_MOD-1:0] module_clk_en,// Per-module clock enable
    output logic                    fwd_mod_wr,   // Module write pulse
    output logic                    fwd_mod_rd,   // Module read pulse
    output logic                    fwd_ps_wr,    // Pin-select write pulse
    output logic      [ADDR_W-1:0]  fwd_addr,     // Forwarded address
    output logic      [31:0]        fwd_wdata,    // Forwarded write data
    output logic                    debug_port_enable,     // Debug port on
    output logic                    two_wire_data_out_use, // Data-out used
    output logic                    pin_select_lock        // Pin-select lock
);

    // Register state
    pdl_word_t          config_control;  // Config and lock flags
    pdl_word_t          dis_reg [NUM_DIS]; // disable_reg_1 .. 6
    pdl_unlock_e        ul_state;        // Unlock sequence state
    pdl_unlock_e        next_ul_state;   // Next unlock state
    logic [NUM_MOD-1:0] dis_vec;         // Flat disable bits
    logic [IDX_W-1:0]   mod_idx;         // Module index of access
    logic               mod_hit;         // Access in module windows
    logic               mod_on;          // Addressed module is enabled
    logic               ps_hit;          // Access in pin-select window
    logic               cfg_hit;         // config_control addressed
    logic               key_hit;         // Key register addressed
    logic [NUM_DIS-1:0] dis_hit;         // Disable register addressed
    logic               dis_lock;        // disable_register_lock
    logic               ps_lock;         // pin_select_lock

    pdl_gate_if gif ();                  // Carrier to the gate

    // Lock flags are fields of config_control
    assign dis_lock = config_control[CFG_DLOCK_BIT];
    assign ps_lock  = config_control[CFG_PLOCK_BIT];

    // Flat disable vector, index 0 is the converter
    assign dis_vec = {
        dis_reg[5][16],    // Parallel port
        dis_reg[5][1],     // Reference clock output
        dis_reg[5][0],     // Clock-calendar
        dis_reg[4][28],    // CAN
        dis_reg[4][24],    // USB
        dis_reg[4][17:16], // I2C 2..1
        dis_reg[4][11:8],  // SPI 4..1
        dis_reg[4][4:0],   // UART 5..1
        dis_reg[3][4:0],   // Timers 5..1
        dis_reg[2][20:16], // Output compare 5..1
        dis_reg[2][4:0],   // Input capture 5..1
        dis_reg[1][2:0],   // Comparators 3..1
        dis_reg[0][12],    // Comparator reference
        dis_reg[0][8],     // current_measurement_unit
        dis_reg[0][0]      // Converter
    };

    // Address decode
    always_comb
    begin
        cfg_hit = (addr == OFF_CFG);
        key_hit = (addr == OFF_KEY);
        for (int i = 0; i < NUM_DIS; i++)
        begin
            dis_hit[i] = (addr == OFF_DIS_BASE + ADDR_W'(4 * i));
        end
        ps_hit  = (addr >= PS_BASE) && (addr < MOD_BASE);
        mod_hit = (addr >= MOD_BASE);
        mod_idx = addr[IDX_LSB +: IDX_W];
        // Indices past the last module count as disabled
        mod_on  = (mod_idx < IDX_W'(NUM_MOD)) && !dis_vec[mod_idx];
    end

    // Unlock sequence: KEY_A then KEY_B as the very next write
    always_comb
    begin
        next_ul_state = ul_state;
        if (wr_en)
        begin
            if (key_hit && wr_data == KEY_A)
                next_ul_state = UL_HALF;           // Start from any state
            else
            begin
                unique case (ul_state)
                    UL_IDLE:
                        next_ul_state = UL_IDLE;
                    UL_HALF:
                        // Anything but the second key breaks the sequence
                        if (key_hit && wr_data == KEY_B)
                            next_ul_state = UL_OPEN;
                        else
                            next_ul_state = UL_IDLE;
                    UL_OPEN:
                        // One config write uses up the opening
                        if (cfg_hit || key_hit)
                            next_ul_state = UL_IDLE;
                        else
                            next_ul_state = UL_OPEN;
                endcase
            end
        end
    end

    // Unlock state register
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ul_state <= UL_IDLE;
        else
            ul_state <= next_ul_state;
    end

    // config_control: debug bits always writable, locks only when open
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            config_control <= CFG_RST;
        else if (wr_en && cfg_hit)
        begin
            config_control[CFG_JTAG_BIT] <= wr_data[CFG_JTAG_BIT];
            config_control[CFG_TDO_BIT]  <= wr_data[CFG_TDO_BIT];
            if (ul_state == UL_OPEN)
            begin
                config_control[CFG_DLOCK_BIT] <= wr_data[CFG_DLOCK_BIT];
                config_control[CFG_PLOCK_BIT] <= wr_data[CFG_PLOCK_BIT];
            end
        end
    end

    // Disable registers, write refused while locked
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_DIS; i++)
            begin
                dis_reg[i] <= DIS_RST;
            end
        end
        else if (wr_en && !dis_lock)
        begin
            for (int i = 0; i < NUM_DIS; i++)
            begin
                if (dis_hit[i])
                    dis_reg[i] <= wr_data & DIS_MASK[i];
            end
        end
    end

    // Read data mux, registered for the next cycle
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data <= '0;
        else if (!rd_en)
            rd_data <= '0;                             // Only valid after read
        else if (cfg_hit)
            rd_data <= config_control & CFG_MASK;
        else if (key_hit)
            rd_data <= {31'h0000_0000, ul_state == UL_OPEN};
        else if (ps_hit)
            rd_data <= periph_rdata;
        else if (mod_hit)
            // Stopped module gives a fixed zero, not garbage
            rd_data <= mod_on ? periph_rdata : '0;
        else
        begin
            rd_data <= '0;                             // Unmapped reads zero
            for (int i = 0; i < NUM_DIS; i++)
            begin
                if (dis_hit[i])
                    rd_data <= dis_reg[i] & DIS_MASK[i];
            end
        end
    end

    // Outputs straight from config_control flops
    assign debug_port_enable     = config_control[CFG_JTAG_BIT];
    assign two_wire_data_out_use = config_control[CFG_TDO_BIT];
    assign pin_select_lock       = ps_lock;

    // Feed the gate; mod_go already folds in the module's disable bit
    // and ps_go the pin-select lock, so the gate only registers them
    assign gif.dis    = dis_vec;
    assign gif.wr     = wr_en;
    assign gif.rd     = rd_en;
    assign gif.addr   = addr;
    assign gif.wdata  = wr_data;
    assign gif.mod_go = mod_hit && mod_on;
    assign gif.ps_go  = ps_hit && !ps_lock;

    // Gating and forwarding
    pdl_gate u_gate (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .g       (gif.gate)
    );

    // Gate outputs are already flops
    assign module_clk_en = gif.clk_en;
    assign fwd_mod_wr    = gif.fwd_mod_wr;
    assign fwd_mod_rd    = gif.fwd_mod_rd;
    assign fwd_ps_wr     = gif.fwd_ps_wr;
    assign fwd_addr      = gif.fwd_addr;
    assign fwd_wdata     = gif.fwd_wdata;

    // Two-step unlock
    sequence unlock_s;
        (wr_en && key_hit && wr_data == KEY_A)
        ##1 (wr_en && key_hit && wr_data == KEY_B);
    endsequence

    // Write to config_control while open
    sequence open_cfg_wr_s;
        (ul_state == UL_OPEN) && wr_en && cfg_hit;
    endsequence

    unlock_open_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        unlock_s |=> ul_state == UL_OPEN)
        else $error("Unlock sequence did not open");

    lock_guard_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$stable({dis_lock, ps_lock}) |-> $past(ul_state) == UL_OPEN)
        else $error("Lock flag changed without unlock");

    lock_take_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        open_cfg_wr_s |=> ps_lock == $past(wr_data[CFG_PLOCK_BIT])
            && dis_lock == $past(wr_data[CFG_DLOCK_BIT]))
        else $error("Lock flags not taken while open");

    dis_locked_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_en && dis_lock && (dis_hit != '0) |=> $stable(dis_vec))
        else $error("Disable register written while locked");

    dis_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_en && !dis_lock && dis_hit[0] && wr_data[0]
            |=> dis_vec[0] ##1 !module_clk_en[0])
        else $error("Disable bit did not stop module");

    ps_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_en && ps_hit |=> fwd_ps_wr == !$past(ps_lock))
        else $error("Pin-select write gating wrong");

    rd_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_en && mod_hit && !mod_on |=> rd_data == '0 && !fwd_mod_rd)
        else $error("Disabled module read not zero");

    jtag_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_en && cfg_hit |=> debug_port_enable == $past(wr_data[3])
            && two_wire_data_out_use == $past(wr_data[0]))
        else $error("Debug bits not written");

    cfg_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_en && cfg_hit |=> (rd_data & ~CFG_MASK) == '0
            && rd_data[0] == two_wire_data_out_use)
        else $error("Unimplemented config bits not zero");

    // Opening is spent by the config write that uses it
    open_used_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        open_cfg_wr_s |=> ul_state == UL_IDLE)
        else $error("Unlock opening not used up");

    // Absent serial and bus bits never read back as set
    dis_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_en && dis_hit[4] |=> (rd_data & ~DIS_MASK[4]) == '0)
        else $error("Unimplemented disable bits read back");

endmodule // pdl_bank

`default_nettype wire

// ===== design/pdl_pkg.sv
/*
 * Constants shared by the peripheral disable and configuration lock block:
 * register offsets, field positions, reset values and the unlock states.
 * Assumes a 13-bit byte address on a plain strobe bus with 32-bit data.
 */
`default_nettype none

package pdl_pkg;

    // Sizes
    localparam int ADDR_W   = 13;                  // Byte address width
    localparam int NUM_MOD  = 37;                  // Gated modules
    localparam int NUM_DIS  = 6;                   // Disable registers
    localparam int IDX_LSB  = 6;                   // Module window is 64 bytes
    localparam int IDX_W    = 6;                   // Module index width

    typedef logic [31:0] pdl_word_t;
    typedef logic [ADDR_W-1:0] pdl_addr_t;

    // Register offsets, byte addresses
    localparam pdl_addr_t OFF_CFG      = 13'h0000; // config_control
    localparam pdl_addr_t OFF_KEY      = 13'h0004; // Unlock key / status
    localparam pdl_addr_t OFF_DIS_BASE = 13'h0010; // disable_reg_1, then +4
    localparam pdl_addr_t PS_BASE      = 13'h0800; // Pin-select window
    localparam pdl_addr_t MOD_BASE     = 13'h1000; // Module register windows

    // config_control fields
    localparam int CFG_TDO_BIT   = 0;              // two_wire_data_out_use
    localparam int CFG_JTAG_BIT  = 3;              // debug_port_enable
    localparam int CFG_DLOCK_BIT = 12;             // disable_register_lock
    localparam int CFG_PLOCK_BIT = 13;             // pin_select_lock
    localparam pdl_word_t CFG_MASK = 32'h0000_3009; // Implemented bits
    localparam pdl_word_t CFG_RST  = 32'h0000_0001; // Value after reset

    // Disable registers: reset and implemented bits
    localparam pdl_word_t DIS_RST = 32'h0000_0000;
    localparam pdl_word_t DIS_MASK [NUM_DIS] = '{
        32'h0000_1101, 32'h0000_0007, 32'h001F_001F,
        32'h0000_001F, 32'h1103_0F1F, 32'h0001_0003};

    // Unlock keys, values arbitrary
    localparam pdl_word_t KEY_A = 32'h3C5A_0F96;
    localparam pdl_word_t KEY_B = 32'hC3A5_F069;

    // Unlock sequence state
    typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_OPEN} pdl_unlock_e;

endpackage

`default_nettype wire

// ===== design/pdl_gate_if.sv
/*
 * Carrier between the register bank and the gating / forwarding module.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface pdl_gate_if
    import pdl_pkg::*;
();
    logic [NUM_MOD-1:0] dis;        // Flat disable vector
    logic               wr;         // Bus write strobe
    logic               rd;         // Bus read strobe
    pdl_addr_t          addr;       // Bus address
    pdl_word_t          wdata;      // Bus write data
    logic               mod_go;     // Module access allowed
    logic               ps_go;      // Pin-select write allowed
    logic [NUM_MOD-1:0] clk_en;     // Per-module clock enables
    logic               fwd_mod_wr; // Forwarded module write
    logic               fwd_mod_rd; // Forwarded module read
    logic               fwd_ps_wr;  // Forwarded pin-select write
    pdl_addr_t          fwd_addr;   // Forwarded address
    pdl_word_t          fwd_wdata;  // Forwarded data

    modport bank (output dis, wr, rd, addr, wdata, mod_go, ps_go,
                  input clk_en, fwd_mod_wr, fwd_mod_rd, fwd_ps_wr,
                  fwd_addr, fwd_wdata);
    modport gate (input dis, wr, rd, addr, wdata, mod_go, ps_go,
                  output clk_en, fwd_mod_wr, fwd_mod_rd, fwd_ps_wr,
                  fwd_addr, fwd_wdata);
endinterface

`default_nettype wire

// ===== design/pdl_gate.sv
/*
 * Clock gating and access forwarding for the peripheral modules.
 * Assumes the bank has already decided whether an access may pass.
 */
`timescale 1ns/100ps
`default_nettype none

module pdl_gate
    import pdl_pkg::*;
(
    input  wire logic sys_clk, // System clock
    input  wire logic sys_rst, // Async reset, high
    pdl_gate_if.gate  g        // Bank side
);

    // Clock enables follow the disable bits one edge later
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            g.clk_en <= '1;           // All modules run after reset
        else
            g.clk_en <= ~g.dis;
    end

    // Strobes only pass for live modules and unlocked pin-select
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            g.fwd_mod_wr <= 1'b0;
            g.fwd_mod_rd <= 1'b0;
            g.fwd_ps_wr  <= 1'b0;
        end
        else
        begin
            g.fwd_mod_wr <= g.wr && g.mod_go;
            g.fwd_mod_rd <= g.rd && g.mod_go;
            g.fwd_ps_wr  <= g.wr && g.ps_go;
        end
    end

    // Address and data ride along with the strobes
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            g.fwd_addr  <= '0;
            g.fwd_wdata <= '0;
        end
        else if (g.wr || g.rd)
        begin
            g.fwd_addr  <= g.addr;
            g.fwd_wdata <= g.wdata;
        end
    end

    // Gate tracks a set disable bit within one edge
    clk_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        g.dis != '0 |=> (g.clk_en & $past(g.dis)) == '0)
        else $error("Disabled module still clocked");

    // A refused write never reaches the module
    blocked_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        g.wr && !g.mod_go |=> !g.fwd_mod_wr)
        else $error("Write reached disabled module");

endmodule // pdl_gate

`default_nettype wire

// ===== bench/pdl_fabric_model.sv
/*
 * Behavioural model of the gated peripheral fabric behind the bank.
 * Assumes one 32-bit control word per module window, read combinationally.
 */
`timescale 1ns/100ps
`default_nettype none

module pdl_fabric_model
    import pdl_pkg::*;
(
    input  wire logic               sys_clk,       // System clock
    input  wire logic [ADDR_W-1:0]  addr,          // Current bus address
    input  wire logic [NUM_MOD-1:0] module_clk_en, // Clock enables
    input  wire logic               fwd_mod_wr,    // Forwarded write
    input  wire logic [ADDR_W-1:0]  fwd_addr,      // Forwarded address
    input  wire logic [31:0]        fwd_wdata,     // Forwarded data
    output logic      [31:0]        periph_rdata   // Read data, same cycle
);
    logic [31:0] mod_reg [64];     // One control word per window
    logic [5:0]  wr_idx;           // Target window of a write

    assign wr_idx = fwd_addr[11:6];

    // Control words start cleared, like modules fresh out of reset
    initial
    begin
        foreach (mod_reg[i])
            mod_reg[i] = 32'h0000_0000;
    end

    // A module without its clock cannot take a write
    always @(posedge sys_clk)
    begin
        if (fwd_mod_wr && wr_idx < NUM_MOD && module_clk_en[wr_idx])
            mod_reg[wr_idx] <= fwd_wdata;
    end

    // Pin-select reads give an address-derived pattern
    assign periph_rdata = addr[12] ? mod_reg[addr[11:6]]
                                   : {16'h5A5A, 3'h0, addr};
endmodule // pdl_fabric_model

`default_nettype wire

// ===== bench/testbench.sv
/*
 * Self-checking bench for the disable and configuration lock bank.
 * Assumes the bank answers reads one cycle after the strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench
    import pdl_pkg::*;
;
    logic               sys_clk, sys_rst, wr_en, rd_en;  // Bus controls
    logic [ADDR_W-1:0]  addr, fwd_addr;                  // Addresses
    logic [31:0]        wr_data, rd_data, periph_rdata;  // Data paths
    logic [31:0]        fwd_wdata, rv;                   // rv: last read
    logic               fwd_mod_wr, fwd_mod_rd, fwd_ps_wr;
    logic               dbg, tdo, plock, fw_mod, fw_ps;  // Seen flags
    logic [NUM_MOD-1:0] clk_en;                          // Clock enables
    int                 err_total, n_compared, cyc;      // Counters
    // Documented register and bit of each module, index order of clk_en
    localparam int DREG [37] = '{0,0,0,1,1,1,2,2,2,2,2,2,2,2,2,2,3,3,3,3,
        3,4,4,4,4,4,4,4,4,4,4,4,4,4,5,5,5};
    localparam int DBIT [37] = '{0,8,12,0,1,2,0,1,2,3,4,16,17,18,19,20,
        0,1,2,3,4,0,1,2,3,4,8,9,10,11,16,17,24,28,0,1,16};

    pdl_bank u_pdl_bank (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .periph_rdata(periph_rdata), .module_clk_en(clk_en),
        .fwd_mod_wr(fwd_mod_wr), .fwd_mod_rd(fwd_mod_rd),
        .fwd_ps_wr(fwd_ps_wr), .fwd_addr(fwd_addr), .fwd_wdata(fwd_wdata),
        .debug_port_enable(dbg), .two_wire_data_out_use(tdo),
        .pin_select_lock(plock));
    pdl_fabric_model u_pdl_fabric_model (.sys_clk(sys_clk), .addr(addr),
        .module_clk_en(clk_en), .fwd_mod_wr(fwd_mod_wr),
        .fwd_addr(fwd_addr), .fwd_wdata(fwd_wdata),
        .periph_rdata(periph_rdata));

    always #10 sys_clk = ~sys_clk;

    // Hang guard, far above the roughly 390 cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic pdl_addr_t daddr(input int r);
        return pdl_addr_t'(OFF_DIS_BASE + 4 * r);
    endfunction

    function automatic pdl_addr_t maddr(input int m);
        return pdl_addr_t'(MOD_BASE + 64 * m);
    endfunction

    // One-cycle write; forward pulses sampled once the edge has landed
    task automatic bus_wr(input pdl_addr_t a, input logic [31:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'h1;
        @(posedge sys_clk);
        wr_en <= 1'h0;
        #1;
        fw_mod = fwd_mod_wr;
        fw_ps  = fwd_ps_wr;
    endtask

    // One-cycle read; data stands only in the following cycle
    task automatic bus_rd(input pdl_addr_t a);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge sys_clk);
        rd_en <= 1'h0;
        #1;
        rv     = rd_data;
        fw_mod = fwd_mod_rd;
    endtask

    // Clock enables trail the disable bits by one edge
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask

    // Both keys back to back, with no gap between the writes
    task automatic unlock();
        @(posedge sys_clk);
        addr    <= OFF_KEY;
        wr_data <= KEY_A;
        wr_en   <= 1'h1;
        @(posedge sys_clk);
        wr_data <= KEY_B;
        @(posedge sys_clk);
        wr_en <= 1'h0;
        #1;
    endtask

    task automatic t_reset();
        check("clk_en", clk_en, {NUM_MOD{1'b1}});
        check("debug_en", dbg, 1'h0);
        check("data_out", tdo, 1'h1);
        bus_rd(OFF_CFG);
        check("cfg", rv, 32'h0000_0001);
        for (int r = 0; r < 6; r++)
        begin
            bus_rd(daddr(r));
            check("dis_reg", rv, 32'h0000_0000);
        end
    endtask

    // Config bits without unlock: lock flags stay, holes read zero
    task automatic t_cfg();
        bus_wr(OFF_CFG, 32'hFFFF_FFFF);
        bus_rd(OFF_CFG);
        check("cfg", rv, 32'h0000_0009);
        check("debug_en", dbg, 1'h1);
        check("data_out", tdo, 1'h1);
        bus_wr(OFF_CFG, 32'h0000_0000);
        check("debug_en", dbg, 1'h0);
        check("data_out", tdo, 1'h0);
    endtask

    // Timer 1 window with its disable bit toggled
    task automatic t_gate();
        bus_wr(maddr(16), 32'h1234_5670);
        check("fwd_wr", fw_mod, 1'h1);
        bus_rd(maddr(16));
        check("mod_rd", rv, 32'h1234_5670);
        check("fwd_rd", fw_mod, 1'h1);
        bus_wr(daddr(3), 32'h0000_0001);
        settle();
        check("clk_en16", clk_en[16], 1'h0);
        bus_wr(maddr(16), 32'hFFFF_FFFF);
        check("fwd_wr", fw_mod, 1'h0);
        bus_rd(maddr(16));
        check("mod_rd", rv, 32'h0000_0000);
        check("fwd_rd", fw_mod, 1'h0);
        bus_wr(daddr(3), 32'h0000_0000);
        settle();
        check("clk_en", clk_en, {NUM_MOD{1'b1}});
        bus_rd(maddr(16));
        check("mod_rd", rv, 32'h1234_5670);
    endtask

    // Every disable bit in place, one module at a time
    task automatic t_bits();
        logic [31:0]        m [6];
        logic [NUM_MOD-1:0] oh;
        for (int r = 0; r < 6; r++)
            m[r] = 32'h0000_0000;
        for (int i = 0; i < NUM_MOD; i++)
        begin
            m[DREG[i]][DBIT[i]] = 1'h1;
            bus_wr(maddr(i), 32'h0000_0000);
        end
        for (int r = 0; r < 6; r++)
        begin
            bus_wr(daddr(r), 32'hFFFF_FFFF);
            bus_rd(daddr(r));
            check("dis_mask", rv, m[r]);
        end
        settle();
        check("clk_en", clk_en, '0);
        for (int r = 0; r < 6; r++)
            bus_wr(daddr(r), 32'h0000_0000);
        for (int i = 0; i < NUM_MOD; i++)
        begin
            oh = '1;
            oh[i] = 1'h0;
            bus_wr(daddr(DREG[i]), 32'h0000_0001 << DBIT[i]);
            settle();
            check("clk_en_bit", clk_en, oh);
            bus_wr(daddr(DREG[i]), 32'h0000_0000);
        end
    endtask

    // Lock flags, broken unlock, pin-select and disable write blocking
    task automatic t_lock();
        unlock();
        bus_rd(OFF_KEY);
        check("unlocked", rv, 32'h0000_0001);
        bus_wr(OFF_CFG, 32'h0000_1001);
        bus_rd(OFF_CFG);
        check("cfg", rv, 32'h0000_1001);
        bus_wr(daddr(0), 32'h0000_0001);
        bus_rd(daddr(0));
        check("dis_lock", rv, 32'h0000_0000);
        check("clk_en0", clk_en[0], 1'h1);
        bus_wr(OFF_CFG, 32'h0000_0001);
        bus_wr(OFF_KEY, KEY_A);
        bus_wr(OFF_KEY, 32'h0000_0000);
        bus_wr(OFF_KEY, KEY_B);
        bus_wr(OFF_CFG, 32'h0000_0001);
        bus_rd(OFF_CFG);
        check("cfg", rv, 32'h0000_1001);
        unlock();
        bus_wr(OFF_CFG, 32'h0000_2001);
        check("ps_lock", plock, 1'h1);
        bus_wr(daddr(0), 32'h0000_0001);
        bus_rd(daddr(0));
        check("dis_open", rv, 32'h0000_0001);
        bus_wr(daddr(0), 32'h0000_0000);
        bus_wr(PS_BASE, 32'h0000_00A5);
        check("ps_wr", fw_ps, 1'h0);
        unlock();
        bus_wr(OFF_CFG, 32'h0000_0001);
        bus_wr(PS_BASE, 32'h0000_00A5);
        check("ps_wr", fw_ps, 1'h1);
        check("fwd_addr", fwd_addr, PS_BASE);
        check("fwd_data", fwd_wdata, 32'h0000_00A5);
        bus_rd(PS_BASE);
        check("ps_rd", rv, 32'h5A5A_0800);
        bus_rd(13'h0100);
        check("unmapped", rv, 32'h0000_0000);
    endtask

    // Reset for four cycles, then the scenarios in turn
    initial
    begin
        sys_clk    = 1'h0;
        sys_rst    = 1'h1;
        addr       = '0;
        wr_data    = 32'h0000_0000;
        wr_en      = 1'h0;
        rd_en      = 1'h0;
        err_total  = 0;
        n_compared = 0;
        cyc        = 0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'h0;
        settle();
        t_reset();
        t_cfg();
        t_gate();
        t_bits();
        t_lock();
        complete_run();
    end
endmodule // testbench

`default_nettype wire
